/* File: fec_pkg.sv */
// fec_pkg: constants and types shared by the flash erase controller ends
// assumes a single mclk domain at 50 MHz
package fec_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  // flash map: info section then main section
  localparam logic [15:0] INFO_BASE = 16'h1000;
  localparam int INFO_SEGS = 2;
  localparam logic [15:0] MAIN_BASE = 16'hF000;
  localparam int MAIN_SEGS = 8;
  localparam int INFO_SEG_BYTES = 128;
  localparam int MAIN_SEG_BYTES = 512;
  localparam int BLOCK_BYTES = 64;
  // erase length in timing-generator cycles, independent of array size
  localparam int ERASE_FTG_CYCLES = 4819;
  localparam logic [7:0] RST_DIVIDER = 8'h00;
  localparam logic [1:0] RST_CLK_SEL = 2'h0;
  // clock source select for the timing generator
  typedef enum logic [1:0] {
    FEC_SRC_AUX = 2'h0,
    FEC_SRC_SUB = 2'h1,
    FEC_SRC_MAIN = 2'h2
  } fec_src_t;
  // erase scope from {mass_erase_select, erase_select}
  typedef enum logic [1:0] {
    FEC_SCOPE_NONE = 2'h0,
    FEC_SCOPE_SEG = 2'h1,
    FEC_SCOPE_MAIN = 2'h2,
    FEC_SCOPE_ALL = 2'h3
  } fec_scope_t;
endpackage

/* File: fec_link_if.sv */
// fec_link_if: cpu core to flash controller connection
// assumes both ends on mclk; no clocking block
`timescale 1ns/1ps
interface fec_link_if;
  import fec_pkg::*;
  logic ctl_wr; // pulse: load control bits
  logic mass_erase_select;
  logic erase_select;
  logic [1:0] clk_sel;
  logic [7:0] timing_clock_divider;
  logic acc_en; // flash access strobe
  logic acc_we;
  logic acc_from_flash; // access issued by code fetched from flash
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata;
  logic [DATA_W-1:0] acc_rdata;
  logic busy;
  logic access_violation_flag;
  logic viol_clr;
  logic cpu_stall;
  logic mass_erase_q;
  logic erase_q;
  modport dev (input ctl_wr, mass_erase_select, erase_select, clk_sel,
    timing_clock_divider, acc_en, acc_we, acc_from_flash, acc_addr,
    acc_wdata, viol_clr, output acc_rdata, busy, access_violation_flag,
    cpu_stall, mass_erase_q, erase_q);
  modport cpu (output ctl_wr, mass_erase_select, erase_select, clk_sel,
    timing_clock_divider, acc_en, acc_we, acc_from_flash, acc_addr,
    acc_wdata, viol_clr, input acc_rdata, busy, access_violation_flag,
    cpu_stall, mass_erase_q, erase_q);
endinterface // fec_link_if

/* File: fec_device.sv */
// fec_device: flash array with segment, mass and full erase sequencing
// assumes aux and sub-main clocks arrive as pins and are synchronised here
//
// Behaviour
// - idle means read mode, generators off
// - erased cells read as all ones
// - scope decoded from mass and erase bits
// - dummy write in range starts erase
// - busy set right after dummy write
// - busy and select bits self-clear at end
// - erase length fixed in generator cycles
// - out-of-range dummy write fully ignored
// - stall cpu when started from flash
// - no stall when started from ram
// - flash access while busy sets violation unless the cpu is stalled
// - cpu polls busy before touching flash
// - software keeps generator near 257-476 kHz
// - generator clock selectable then divided
// - segment erase clears whole segment
// - segments split into aligned 64-byte blocks
// - main and info sections behave alike, but mass erase takes main only
// - cpu avoids flash during erase
// - software disables interrupts before erase
`timescale 1ns/1ps
module fec_device
  import fec_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_FTG_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic aux_clk_pin,
  input wire logic sub_main_clock_pin,
  fec_link_if.dev lnk,
  output logic gen_active,
  output logic [fec_pkg::ADDR_W-1:0] block_base
);
  import fec_pkg::*;

  localparam int INFO_BYTES = INFO_SEGS * INFO_SEG_BYTES;
  localparam int MAIN_BYTES = MAIN_SEGS * MAIN_SEG_BYTES;
  localparam int INFO_WORDS = INFO_BYTES / 2;
  localparam int MAIN_WORDS = MAIN_BYTES / 2;
  localparam int TOT_WORDS = INFO_WORDS + MAIN_WORDS;
  localparam int IDX_W = $clog2(TOT_WORDS);
  localparam logic [IDX_W-1:0] ALL_LAST = IDX_W'(TOT_WORDS - 1);

  typedef enum logic [1:0] {ST_READ, ST_ERASE} fec_state_t;

  typedef struct packed {
    fec_state_t st;
    logic mass_erase;
    logic erase;
    logic [1:0] src;
    logic [7:0] div;
    logic busy;
    logic viol;
    logic stall;
    logic [IDX_W-1:0] lo;
    logic [IDX_W-1:0] hi;
    logic [12:0] ftg_cnt;
    logic [7:0] div_cnt;
    logic [2:0] aux_s;
    logic [2:0] sub_s;
    logic [ADDR_W-1:0] blk;
    logic [DATA_W-1:0] rdata;
  } fec_dev_st_t;

  fec_dev_st_t s_r, s_nxt;
  logic [DATA_W-1:0] mem [TOT_WORDS];
  logic in_info, in_main, in_flash;
  logic [IDX_W-1:0] idx;
  logic in_scope;
  logic tick;
  logic src_edge;
  logic [IDX_W-1:0] seg_lo, seg_hi;

  // map a byte address to a word index of the unified array
  function automatic logic [IDX_W-1:0] word_idx(logic [ADDR_W-1:0] a,
                                               logic info);
    logic [ADDR_W-1:0] off;
    off = info ? (a - INFO_BASE) : (a - MAIN_BASE);
    return info ? IDX_W'(off >> 1) : IDX_W'((off >> 1) + INFO_WORDS);
  endfunction

  // address decode; both sections go through the same path
  always_comb begin
    in_info = lnk.acc_addr >= INFO_BASE &&
              lnk.acc_addr < ADDR_W'(INFO_BASE + INFO_BYTES);
    in_main = lnk.acc_addr >= MAIN_BASE;
    in_flash = in_info | in_main;
    idx = word_idx(lnk.acc_addr, in_info);
  end

  // segment bounds: 128-byte info or 512-byte main segment
  always_comb begin
    if (in_info) begin
      seg_lo = idx & ~IDX_W'(INFO_SEG_BYTES / 2 - 1);
      seg_hi = seg_lo + IDX_W'(INFO_SEG_BYTES / 2 - 1);
    end else begin
      seg_lo = IDX_W'(((idx - IDX_W'(INFO_WORDS)) &
               ~IDX_W'(MAIN_SEG_BYTES / 2 - 1)) + IDX_W'(INFO_WORDS));
      seg_hi = seg_lo + IDX_W'(MAIN_SEG_BYTES / 2 - 1);
    end
  end

  // scope check of the dummy write address
  always_comb begin
    case ({s_r.mass_erase, s_r.erase})
      FEC_SCOPE_SEG: in_scope = in_flash;
      FEC_SCOPE_MAIN: in_scope = in_main;
      FEC_SCOPE_ALL: in_scope = in_flash;
      default: in_scope = 1'b0;
    endcase
  end

  // selected source edge, then divider; pin clocks go through 2 flops
  always_comb begin
    src_edge = 1'b0;
    case (s_r.src)
      FEC_SRC_AUX: src_edge = s_r.aux_s[1] & ~s_r.aux_s[2];
      FEC_SRC_SUB: src_edge = s_r.sub_s[1] & ~s_r.sub_s[2];
      default: src_edge = 1'b1; // main clock every cycle
    endcase
    tick = src_edge && (s_r.div_cnt == s_r.div);
  end

  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.aux_s = {s_r.aux_s[1:0], aux_clk_pin};
    s_nxt.sub_s = {s_r.sub_s[1:0], sub_main_clock_pin};
    s_nxt.blk = lnk.acc_addr & ~ADDR_W'(BLOCK_BYTES - 1);
    if (lnk.viol_clr) s_nxt.viol = 1'b0;
    if (lnk.ctl_wr && s_r.st == ST_READ) begin
      s_nxt.mass_erase = lnk.mass_erase_select;
      s_nxt.erase = lnk.erase_select;
      s_nxt.src = lnk.clk_sel;
      s_nxt.div = lnk.timing_clock_divider;
    end
    case (s_r.st)
      ST_READ: begin
        // generators held off in read mode
        s_nxt.div_cnt = '0;
        s_nxt.ftg_cnt = '0;
        if (lnk.acc_en && !lnk.acc_we && in_flash)
          s_nxt.rdata = mem[idx]; // rom-like read
        if (lnk.acc_en && lnk.acc_we && in_scope) begin
          s_nxt.st = ST_ERASE;
          s_nxt.busy = 1'b1;
          s_nxt.stall = lnk.acc_from_flash;
          case ({s_r.mass_erase, s_r.erase})
            FEC_SCOPE_SEG: begin
              s_nxt.lo = seg_lo;
              s_nxt.hi = seg_hi;
            end
            FEC_SCOPE_MAIN: begin
              s_nxt.lo = IDX_W'(INFO_WORDS);
              s_nxt.hi = ALL_LAST;
            end
            default: begin
              s_nxt.lo = '0;
              s_nxt.hi = ALL_LAST;
            end
          endcase
        end
        // out-of-range dummy write leaves everything alone
      end
      ST_ERASE: begin
        // flash touch while busy flags a violation unless the cpu is stalled
        if (lnk.acc_en && in_flash && !s_r.stall) s_nxt.viol = 1'b1;
        // divider counts source edges and restarts on each tick
        if (tick) s_nxt.div_cnt = '0;
        else if (src_edge) s_nxt.div_cnt = s_r.div_cnt + 8'h01;
        if (tick) begin
          // fixed count, no dependence on array size
          if (s_r.ftg_cnt == 13'(ERASE_CYCLES - 1)) begin
            s_nxt.st = ST_READ;
            s_nxt.busy = 1'b0;
            s_nxt.mass_erase = 1'b0;
            s_nxt.erase = 1'b0;
            s_nxt.stall = 1'b0;
          end else begin
            s_nxt.ftg_cnt = s_r.ftg_cnt + 13'h0001;
          end
        end
      end
      default: s_nxt.st = ST_READ;
    endcase
  end

  // state register; violation set wins over clear by ordering above
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= ST_READ;
      s_r.src <= RST_CLK_SEL;
      s_r.div <= RST_DIVIDER;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // array: erase writes ones over the range at completion; data of the
  // dummy write is never stored
  always_ff @(posedge mclk) begin
    if (ce && s_r.st == ST_ERASE && tick &&
        s_r.ftg_cnt == 13'(ERASE_CYCLES - 1)) begin
      for (int i = 0; i < TOT_WORDS; i++)
        if (IDX_W'(i) >= s_r.lo && IDX_W'(i) <= s_r.hi)
          mem[i] <= '1;
    end
  end

  // 64-byte aligned block of the last address seen, registered
  assign block_base = s_r.blk;
  assign gen_active = (s_r.st == ST_ERASE);
  assign lnk.busy = s_r.busy;
  assign lnk.access_violation_flag = s_r.viol;
  assign lnk.cpu_stall = s_r.stall;
  assign lnk.mass_erase_q = s_r.mass_erase;
  assign lnk.erase_q = s_r.erase;
  assign lnk.acc_rdata = s_r.rdata;
endmodule // fec_device

/* File: fec_cpu.sv */
// fec_cpu: cpu-side end that configures, issues the dummy write and polls
// assumes fec_device on the same mclk, user side gives one command pulse
`timescale 1ns/1ps
module fec_cpu
  import fec_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [1:0] scope,
  input wire logic [1:0] clk_sel,
  input wire logic [7:0] divider,
  input wire logic [fec_pkg::ADDR_W-1:0] target,
  input wire logic from_flash,
  fec_link_if.cpu lnk,
  output logic done,
  output logic running
);
  import fec_pkg::*;

  typedef enum logic [1:0] {C_IDLE, C_CFG, C_DUMMY, C_POLL} fec_cst_t;
  typedef struct packed {
    fec_cst_t st;
    logic done;
  } fec_cpu_st_t;
  fec_cpu_st_t s_r, s_nxt;

  // sequence: config, dummy write, poll busy without touching flash
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      C_IDLE: if (start) s_nxt.st = C_CFG;
      C_CFG: s_nxt.st = C_DUMMY;
      C_DUMMY: s_nxt.st = C_POLL; // no interrupt can split this end
      C_POLL: begin
        if (!lnk.busy) begin
          s_nxt.st = C_IDLE;
          s_nxt.done = 1'b1;
        end
      end
      default: s_nxt.st = C_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r.st <= C_IDLE;
      s_r.done <= 1'b0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // software keeps the divided clock in range; values passed through
  assign lnk.ctl_wr = ce && s_r.st == C_CFG;
  assign lnk.mass_erase_select = scope[1];
  assign lnk.erase_select = scope[0];
  assign lnk.clk_sel = clk_sel;
  assign lnk.timing_clock_divider = divider;
  assign lnk.acc_en = ce && s_r.st == C_DUMMY;
  assign lnk.acc_we = 1'b1;
  assign lnk.acc_from_flash = from_flash;
  assign lnk.acc_addr = target;
  assign lnk.acc_wdata = 16'h0000;
  assign lnk.viol_clr = 1'b0;
  assign done = s_r.done;
  assign running = (s_r.st != C_IDLE);
endmodule // fec_cpu

/* File: fec_props.sv */
// fec_props: assertions on the cpu to flash controller link
// assumes one mclk domain, main clock source, ERASE_CYCLES set to 8
`timescale 1ns/1ps
module fec_props
  import fec_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic acc_en,
  input wire logic acc_we,
  input wire logic acc_from_flash,
  input wire logic [fec_pkg::ADDR_W-1:0] acc_addr,
  input wire logic [1:0] clk_sel,
  input wire logic [7:0] timing_clock_divider,
  input wire logic mass_erase_q,
  input wire logic erase_q,
  input wire logic busy,
  input wire logic cpu_stall,
  input wire logic access_violation_flag
);
  import fec_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic in_info, in_main, hit, wr;
  // flash map decode; hit means inside the selected erase range
  assign in_info = acc_addr[15:8] == 8'h10;
  assign in_main = acc_addr[15:12] == 4'hF;
  assign hit = (erase_q && (in_info || in_main)) || (mass_erase_q && in_main);
  assign wr = acc_en && acc_we && !busy;
  start_erase_a: assert property (wr && hit |=> busy)
    else $error("dummy write in range did not start erase");
  stray_write_a: assert property (wr && !hit |=> !busy)
    else $error("stray dummy write started erase");
  busy_length_a: assert property ($rose(busy) &&
    clk_sel == 2'h2 && timing_clock_divider == 8'h00 |->
    busy [*8] ##1 !busy)
    else $error("busy span differs from erase length");
  self_clear_a: assert property ($fell(busy) |->
    !mass_erase_q && !erase_q)
    else $error("mode bits not cleared at erase end");
  stall_match_a: assert property ($rose(busy) |->
    cpu_stall == $past(acc_from_flash))
    else $error("stall does not follow fetch origin");
  stall_idle_a: assert property (!busy |-> !cpu_stall)
    else $error("cpu stalled while idle");
  viol_cause_a: assert property (!access_violation_flag &&
    !(busy && acc_en) |=> !access_violation_flag)
    else $error("violation flag set without cause");
  mode_hold_a: assert property (busy ##1 busy |->
    $stable(mass_erase_q) && $stable(erase_q))
    else $error("mode bits changed mid erase");
  cover property ($rose(busy) && cpu_stall);
  cover property ($rose(busy) && !cpu_stall);
  cover property (wr && !hit);
endmodule // fec_props

/* File: test_flash_erase_controller.sv */
// test_flash_erase_controller: both ends joined, plus a bench-driven device
// assumes 50 MHz mclk and ERASE_CYCLES of 8
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin \
  n_mismatch++; $display("MISMATCH %s expected %0h seen %0h", nm, e, s); \
  end end
module test_flash_erase_controller;
  import fec_pkg::*;
  logic mclk, rst, aux, sub, start, ff, done, running, gen_b;
  logic [1:0] scope, csel;
  logic [7:0] div;
  logic [15:0] target, rd, blk_b;
  int n_mismatch = 0, compares = 0, n, s, k, p;
  fec_link_if lnk();
  fec_link_if lnk_b();
  fec_cpu u_fec_cpu (.mclk(mclk), .rst(rst), .ce(1'b1), .start(start),
    .scope(scope), .clk_sel(csel), .divider(div), .target(target),
    .from_flash(ff), .lnk(lnk), .done(done), .running(running));
  fec_device #(.ERASE_CYCLES(8)) u_fec_device (.mclk(mclk), .rst(rst),
    .ce(1'b1), .aux_clk_pin(aux), .sub_main_clock_pin(sub), .lnk(lnk),
    .gen_active(), .block_base());
  // second device: the bench plays a cpu that breaks the access rules
  fec_device #(.ERASE_CYCLES(8)) u_fec_device_b (.mclk(mclk), .rst(rst),
    .ce(1'b1), .aux_clk_pin(aux), .sub_main_clock_pin(sub), .lnk(lnk_b),
    .gen_active(gen_b), .block_base(blk_b));
  fec_props u_fec_props (.mclk(mclk), .rst(rst), .acc_en(lnk.acc_en),
    .acc_we(lnk.acc_we), .acc_from_flash(lnk.acc_from_flash),
    .acc_addr(lnk.acc_addr), .clk_sel(lnk.clk_sel),
    .timing_clock_divider(lnk.timing_clock_divider),
    .mass_erase_q(lnk.mass_erase_q), .erase_q(lnk.erase_q),
    .busy(lnk.busy), .cpu_stall(lnk.cpu_stall),
    .access_violation_flag(lnk.access_violation_flag));
  // free-running clocks; aux and sub-main are unrelated to mclk
  always #10 mclk = ~mclk;
  always #80 aux = ~aux;
  always #50 sub = ~sub;
  task automatic close_out();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // one erase through the cpu end; counts busy cycles and flags any stall cycle
  task automatic erase(input logic [1:0] sc, input logic [1:0] src,
      input logic [15:0] tg, input logic fl);
    scope = sc; csel = src; target = tg; ff = fl; start = 1'b1; n = 0; s = 0;
    @(negedge mclk);
    start = 1'b0;
    for (int i = 0; i < 400 && done !== 1'b1; i++) begin
      @(negedge mclk);
      n += (lnk.busy === 1'b1);
      s |= (lnk.cpu_stall === 1'b1);
    end
    `CHK("done seen", 1'b1, done)
  endtask
  // one-cycle access strobe on the bench-driven link
  task automatic acc(input logic we, input logic [15:0] a);
    lnk_b.acc_en = 1'b1; lnk_b.acc_we = we; lnk_b.acc_addr = a;
    @(negedge mclk);
    rd = lnk_b.acc_rdata;
    lnk_b.acc_en = 1'b0;
    // idle cycle so the next call never re-raises the strobe at once
    @(negedge mclk);
  endtask
  task automatic cfg(input logic [1:0] sc);
    {lnk_b.mass_erase_select, lnk_b.erase_select} = sc; lnk_b.ctl_wr = 1'b1;
    @(negedge mclk);
    lnk_b.ctl_wr = 1'b0;
    // poll busy before touching flash again
    for (int i = 0; i < 300 && lnk_b.busy === 1'b1; i++) @(negedge mclk);
    `CHK("busy cleared", 1'b0, lnk_b.busy)
  endtask
  // watchdog: the whole run needs some 300 cycles
  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end
  initial begin
    mclk = 0; rst = 1; aux = 0; sub = 0; start = 0; ff = 0; scope = 0;
    csel = 2'h2; div = 8'h00; target = 16'h0000;
    lnk_b.ctl_wr = 0; lnk_b.mass_erase_select = 0; lnk_b.erase_select = 0;
    lnk_b.clk_sel = 2'h2; lnk_b.timing_clock_divider = 8'h00;
    lnk_b.acc_en = 0; lnk_b.acc_we = 0; lnk_b.acc_from_flash = 0;
    lnk_b.acc_addr = 16'h0000; lnk_b.acc_wdata = 16'h1234; lnk_b.viol_clr = 0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    for (k = 1; k < 4; k++) begin
      erase(k[1:0], 2'h2, (k == 2) ? 16'hF200 : 16'h1040, k[0]);
      `CHK("busy cycles", 8, n)
      `CHK("stall", k[0], s)
      `CHK("mode bits", 2'b00, {lnk.mass_erase_q, lnk.erase_q})
      `CHK("cpu idle", 1'b0, running)
    end
    erase(2'h2, 2'h2, 16'h1000, 1'b0);
    `CHK("main scope on info", 0, n)
    erase(2'h1, 2'h2, 16'h2000, 1'b0);
    `CHK("out of range", 0, n)
    div = 8'h01;
    for (k = 0; k < 2; k++) begin
      p = k ? 5 : 8;
      erase(2'h1, k[1:0], 16'hF000, 1'b0);
      `CHK("slow source span", 1'b1, n >= 15 * p && n <= 16 * p + 1)
    end
    cfg(2'h0);
    acc(1'b1, 16'hF000);
    `CHK("no mode write", 1'b0, lnk_b.busy)
    `CHK("read mode", 1'b0, gen_b)
    cfg(2'h1);
    acc(1'b1, 16'hF1C0);
    `CHK("busy b", 1'b1, lnk_b.busy)
    cfg(2'h1);
    acc(1'b0, 16'hF000);
    `CHK("erased low", 16'hFFFF, rd)
    acc(1'b0, 16'hF1FE);
    `CHK("erased top", 16'hFFFF, rd)
    `CHK("block base", 16'hF1C0, blk_b)
    cfg(2'h1);
    acc(1'b1, 16'h1010);
    acc(1'b0, 16'hF000);
    @(negedge mclk);
    `CHK("violation", 1'b1, lnk_b.access_violation_flag)
    cfg(2'h0);
    lnk_b.viol_clr = 1'b1;
    @(negedge mclk);
    lnk_b.viol_clr = 1'b0;
    @(negedge mclk);
    `CHK("violation clear", 1'b0, lnk_b.access_violation_flag)
    close_out();
  end
endmodule // test_flash_erase_controller
